// ---- common/dsf_map.svh ----
// Functional notes
// - Link loss only in RTU over RS-485
// - Timeout sets link loss until next data
// - Timeout 0.00 to 99.99 s, default 0.00
// - Code 32 routes link loss
// - Run seen while run command received
// - Both run inputs active stops drive
// - Code 41 routes run seen
// - Heatsink warning when temperature exceeds threshold
// - Heatsink threshold 0 to 110, default 100
// - Code 42 routes heatsink warning
// - Undercurrent when current below threshold, per mode
// - Mode 00 always, 01 constant speed only
// - Undercurrent threshold 0 to 2x rated
// - Code 43 routes undercurrent
// - Ready flag when drive accepts run
// - Run ignored while not ready; code blocks only a start, motionState stays running if ready drops
// - Code 50 routes ready flag
// - Forward flag only running forward, code 51
// - Reverse flag only running reverse, code 52
//
// Purpose: Register map and constants for drive status outputs
// Assumes: APB word registers, 100 MHz clock
// Notes: Settings in hundredths of a second, degrees C, percent of rated
`ifndef DSF_MAP_SVH
`define DSF_MAP_SVH
`define DSF_CLK_HZ 100000000
`define DSF_TICK_CYCLES (`DSF_CLK_HZ / 100)
`define DSF_OFF_TIMEOUT 12'h000
`define DSF_OFF_HEAT 12'h004
`define DSF_OFF_UCUR 12'h008
`define DSF_OFF_SEL 12'h00c
`define DSF_OFF_CTRL 12'h010
`define DSF_OFF_STAT 12'h014
`define DSF_TIMEOUT_MAX 16'd9999
`define DSF_TIMEOUT_RST 16'd0
`define DSF_HEAT_MAX 8'd110
`define DSF_HEAT_RST 8'd100
`define DSF_UCUR_MAX 8'd200
`define DSF_UCUR_RST 8'd100
`define DSF_MODE_RST 1'b1
`define DSF_CODE_LINK 6'd32
`define DSF_CODE_RUNSEEN 6'd41
`define DSF_CODE_HEAT 6'd42
`define DSF_CODE_UCUR 6'd43
`define DSF_CODE_READY 6'd50
`define DSF_CODE_FWD 6'd51
`define DSF_CODE_REV 6'd52
`endif

// ---- common/dsf_pkg.sv ----
// Purpose: Types for drive status outputs
// Assumes: Constants live in dsf_map.svh
// Notes: Motion states seen by the flag logic
package dsf_pkg;
  typedef enum logic [1:0] {
    DSF_STOPPED,
    DSF_AHEAD,
    DSF_BACKWARD
  } dsf_motion_type;
endpackage

// ---- logic/dsf_status_outputs.sv ----
// Purpose: Drive status flags routed to two output terminals and a relay
// Assumes: Inputs synchronous to clk_sys, APB slave for settings
// Notes: Flags registered, outputs one cycle after the flags
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "dsf_map.svh"
module dsf_status_outputs #(
  parameter int TICK_CYCLES = `DSF_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rtuRs485Sel,
  input wire logic rxDataStrobe,
  input wire logic aheadRunInput,
  input wire logic backwardRunInput,
  input wire logic supplyInRange,
  input wire logic constantSpeed,
  input wire logic [7:0] heatsinkTemp,
  input wire logic [7:0] outputCurrentPct,
  output logic [5:0] linkLossFlagOut,
  output logic driveRunEnable,
  output dsf_pkg::dsf_motion_type motionState,
  output logic outputTerminalOne,
  output logic outputTerminalTwo,
  output logic relayOutput
);
  import dsf_pkg::*;

  // Settings
  logic [15:0] linkTimeoutSetting_q;
  logic [7:0] heatsinkWarnThreshold_q;
  logic [7:0] undercurrentThreshold_q;
  logic undercurrentModeSelect_q;
  // Index 0 terminal one, 1 terminal two, 2 relay
  logic [5:0] selCode_q [3];
  logic outLine_q [3];

  // Link supervision
  logic [31:0] tickCnt_q;
  logic tickDone;
  logic [15:0] timeoutCnt_q;
  logic timeoutReached;

  // Status flags
  logic linkLossFlag_q;
  logic runCommandSeen_q;
  logic heatsinkHotWarn_q;
  logic undercurrentFlag_q;
  logic driveReadyFlag_q;
  logic turningAheadFlag_q;
  logic turningBackwardFlag_q;

  // Decodes
  logic runRequest;
  logic conflict;
  logic access;
  logic setupPhase;
  logic writeHit;
  logic ucurWindow;
  logic [6:0] flagVec;
  logic [31:0] readWord_d;

  assign access = psel && penable;
  assign setupPhase = psel && !penable;
  // A write lands only at the edge that completes the access
  assign writeHit = access && pready && pwrite;
  assign runRequest = aheadRunInput ^ backwardRunInput;
  assign conflict = aheadRunInput && backwardRunInput;
  assign tickDone = tickCnt_q == 32'(TICK_CYCLES - 1);
  assign timeoutReached = (linkTimeoutSetting_q != 16'h0000) &&
                          (timeoutCnt_q >= linkTimeoutSetting_q);
  // Mode 0 checks at any speed, mode 1 only at constant speed
  assign ucurWindow = (motionState != DSF_STOPPED) &&
                      (!undercurrentModeSelect_q || constantSpeed);
  assign flagVec = {
    turningBackwardFlag_q,
    turningAheadFlag_q,
    driveReadyFlag_q,
    undercurrentFlag_q,
    heatsinkHotWarn_q,
    runCommandSeen_q,
    linkLossFlag_q
  };

  // Zero wait states: the access phase always completes in one cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPhase;
    end
  end

  function automatic logic mapped(input logic [11:0] a);
    unique case (a)
      `DSF_OFF_TIMEOUT, `DSF_OFF_HEAT, `DSF_OFF_UCUR: mapped = 1'b1;
      `DSF_OFF_SEL, `DSF_OFF_CTRL, `DSF_OFF_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Settings writes; field values above the limit are clamped, pwdata bits above each field are dropped
  // Timeout counts hundredths of a second
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      linkTimeoutSetting_q <= `DSF_TIMEOUT_RST;
    end else if (writeHit && paddr == `DSF_OFF_TIMEOUT) begin
      if (pwdata[15:0] > `DSF_TIMEOUT_MAX) begin
        linkTimeoutSetting_q <= `DSF_TIMEOUT_MAX;
      end else begin
        linkTimeoutSetting_q <= pwdata[15:0];
      end
    end
  end

  // Threshold in whole degrees
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      heatsinkWarnThreshold_q <= `DSF_HEAT_RST;
    end else if (writeHit && paddr == `DSF_OFF_HEAT) begin
      if (pwdata[7:0] > `DSF_HEAT_MAX) begin
        heatsinkWarnThreshold_q <= `DSF_HEAT_MAX;
      end else begin
        heatsinkWarnThreshold_q <= pwdata[7:0];
      end
    end
  end

  // Threshold is in percent of rated current, so 200 is twice rated
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      undercurrentThreshold_q <= `DSF_UCUR_RST;
    end else if (writeHit && paddr == `DSF_OFF_UCUR) begin
      if (pwdata[7:0] > `DSF_UCUR_MAX) begin
        undercurrentThreshold_q <= `DSF_UCUR_MAX;
      end else begin
        undercurrentThreshold_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      undercurrentModeSelect_q <= `DSF_MODE_RST;
    end else if (writeHit && paddr == `DSF_OFF_CTRL) begin
      undercurrentModeSelect_q <= pwdata[0];
    end
  end

  // One select field per output, each in its own byte of the word
  for (genvar i = 0; i < 3; i++) begin : g_sel
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        selCode_q[i] <= 6'h00;
      end else if (writeHit && paddr == `DSF_OFF_SEL) begin
        selCode_q[i] <= pwdata[8 * i +: 6];
      end
    end
  end

  // Read word is decoded in the setup phase and held through the access
  always_comb begin
    readWord_d = 32'h0000_0000;
    unique case (paddr)
      `DSF_OFF_TIMEOUT: readWord_d = {16'h0000, linkTimeoutSetting_q};
      `DSF_OFF_HEAT: readWord_d = {24'h000000, heatsinkWarnThreshold_q};
      `DSF_OFF_UCUR: readWord_d = {24'h000000, undercurrentThreshold_q};
      `DSF_OFF_SEL: readWord_d = {10'h000, selCode_q[2], 2'h0, selCode_q[1], 2'h0, selCode_q[0]};
      `DSF_OFF_CTRL: readWord_d = {31'h00000000, undercurrentModeSelect_q};
      `DSF_OFF_STAT: readWord_d = {25'h0000000, flagVec};
      default: readWord_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata <= readWord_d;
    end
  end

  // Error flag stands only in the access cycle, together with pready
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setupPhase && !mapped(paddr);
    end
  end

  // Hundredth-second tick; restarts on each received byte
  always_ff @(posedge clk_sys) begin
    if (reset || rxDataStrobe || tickDone) begin
      tickCnt_q <= 32'h0000_0000;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h0000_0001;
    end
  end

  // A zero timeout setting disables detection
  always_ff @(posedge clk_sys) begin
    if (reset || rxDataStrobe || !rtuRs485Sel) begin
      timeoutCnt_q <= 16'h0000;
    end else if (tickDone) begin
      // Saturate so a long silence never wraps back below the setting
      if (timeoutCnt_q != 16'hffff) begin
        timeoutCnt_q <= timeoutCnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !rtuRs485Sel) begin
      linkLossFlag_q <= 1'b0;
    end else if (rxDataStrobe) begin
      // Fresh data proves the link alive, so it outranks a set
      linkLossFlag_q <= 1'b0;
    end else if (timeoutReached) begin
      linkLossFlag_q <= 1'b1;
    end
  end

  // Either input counts, even the conflicting pair that stops the drive
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      runCommandSeen_q <= 1'b0;
    end else begin
      runCommandSeen_q <= aheadRunInput || backwardRunInput;
    end
  end

  // Strictly greater, so a temperature equal to the threshold stays quiet
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      heatsinkHotWarn_q <= 1'b0;
    end else begin
      heatsinkHotWarn_q <= heatsinkTemp > heatsinkWarnThreshold_q;
    end
  end

  // Undercurrent is only meaningful while the motor is driven
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      undercurrentFlag_q <= 1'b0;
    end else begin
      undercurrentFlag_q <= ucurWindow &&
                            (outputCurrentPct < undercurrentThreshold_q);
    end
  end

  // Ready follows the supply check one cycle late
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      driveReadyFlag_q <= 1'b0;
    end else begin
      driveReadyFlag_q <= supplyInRange;
    end
  end

  // Enable follows the same gating as the start of motion
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      driveRunEnable <= 1'b0;
    end else begin
      driveRunEnable <= runRequest && !conflict && driveReadyFlag_q;
    end
  end

  // Run starts only when ready; both inputs at once force a stop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      motionState <= DSF_STOPPED;
    end else if (conflict || !runRequest) begin
      motionState <= DSF_STOPPED;
    end else if (motionState == DSF_STOPPED && driveReadyFlag_q) begin
      motionState <= aheadRunInput ? DSF_AHEAD : DSF_BACKWARD;
    end else if (motionState != DSF_STOPPED) begin
      motionState <= aheadRunInput ? DSF_AHEAD : DSF_BACKWARD;
    end
  end

  // Direction flags trail the motion register by one cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      turningAheadFlag_q <= 1'b0;
    end else begin
      turningAheadFlag_q <= motionState == DSF_AHEAD;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      turningBackwardFlag_q <= 1'b0;
    end else begin
      turningBackwardFlag_q <= motionState == DSF_BACKWARD;
    end
  end

  function automatic logic pick(input logic [5:0] code);
    unique case (code)
      `DSF_CODE_LINK: pick = linkLossFlag_q;
      `DSF_CODE_RUNSEEN: pick = runCommandSeen_q;
      `DSF_CODE_HEAT: pick = heatsinkHotWarn_q;
      `DSF_CODE_UCUR: pick = undercurrentFlag_q;
      `DSF_CODE_READY: pick = driveReadyFlag_q;
      `DSF_CODE_FWD: pick = turningAheadFlag_q;
      `DSF_CODE_REV: pick = turningBackwardFlag_q;
      default: pick = 1'b0;
    endcase
  endfunction

  // Each output re-reads its select every cycle, so a new code reaches the output one cycle after the write
  for (genvar i = 0; i < 3; i++) begin : g_out
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        outLine_q[i] <= 1'b0;
      end else begin
        outLine_q[i] <= pick(selCode_q[i]);
      end
    end
  end

  assign outputTerminalOne = outLine_q[0];
  assign outputTerminalTwo = outLine_q[1];
  assign relayOutput = outLine_q[2];

  // Only bit 0 carries the flag; upper bits read as zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      linkLossFlagOut <= 6'h00;
    end else begin
      linkLossFlagOut <= {5'h00, linkLossFlag_q};
    end
  end
endmodule // dsf_status_outputs

// ---- tb/dsf_status_outputs_chk.sv ----
// Purpose: Port checker for the status outputs
// Assumes: One clock, sync reset
// Notes: Bound below the module
`timescale 1ns/1ps
module dsf_status_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rtuRs485Sel,
  input wire logic rxDataStrobe,
  input wire logic aheadRunInput,
  input wire logic backwardRunInput,
  input wire logic supplyInRange,
  input wire logic [5:0] linkLossFlagOut,
  input wire dsf_pkg::dsf_motion_type motionState,
  input wire logic outputTerminalOne
);
  import dsf_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_RST: assert property (disable iff (1'b0) reset |=> !outputTerminalOne
    && motionState == DSF_STOPPED) else $error("reset");
  AST_BOTH: assert property (aheadRunInput && backwardRunInput
    |=> motionState == DSF_STOPPED) else $error("both");
  AST_NRDY: assert property (!supplyInRange [*2] |=> motionState == DSF_STOPPED)
    else $error("ready");
  AST_AHEAD: assert property ((aheadRunInput && !backwardRunInput && supplyInRange) [*3]
    |=> motionState == DSF_AHEAD) else $error("ahead");
  AST_PRDY: assert property (psel && !penable |=> pready) else $error("pready");
  AST_PULSE: assert property (pready |=> !pready) else $error("pulse");
  AST_ERR: assert property (pslverr |-> pready) else $error("slverr");
  AST_RTU: assert property (!rtuRs485Sel |-> ##2 linkLossFlagOut == 6'h00) else $error("rtu");
  AST_RX: assert property (rxDataStrobe |-> ##2 !linkLossFlagOut[0]) else $error("rx");
endmodule // dsf_status_chk
bind dsf_status_outputs dsf_status_chk u_dsf_status_chk (.clk_sys, .reset, .psel, .penable,
  .pready, .pslverr, .rtuRs485Sel, .rxDataStrobe, .aheadRunInput, .backwardRunInput,
  .supplyInRange, .linkLossFlagOut, .motionState, .outputTerminalOne);

// ---- tb/dsf_far_ctrl.sv ----
// Purpose: Far-side controller input card
// Assumes: Scans on the drive clock
// Notes: Adds one cycle to what the bench sees
`timescale 1ns/1ps
module dsf_far_ctrl (
  input wire logic clk_sys,
  input wire logic termOne,
  input wire logic termTwo,
  input wire logic relayIn,
  output logic [2:0] seenLines
);
  always_ff @(posedge clk_sys) begin
    seenLines <= {termOne, termTwo, relayIn};
  end
endmodule // dsf_far_ctrl

// ---- tb/dsf_status_outputs_test.sv ----
// Purpose: Bench for the status outputs
// Assumes: Tick shortened to 10 cycles
// Notes: Terminals read through the far-side model
`timescale 1ns/1ps
module dsf_status_outputs_test;
  import dsf_pkg::*;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, rtuRs485Sel, rxDataStrobe, er;
  logic aheadRunInput, backwardRunInput, supplyInRange, constantSpeed, t1, t2, rl, runEn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] heatsinkTemp, outputCurrentPct;
  logic [5:0] linkLossFlagOut;
  logic [2:0] seenLines;
  dsf_motion_type motionState;
  logic [31:0] rstVal [7] = '{32'h0, 32'h64, 32'h64, 32'h0, 32'h1, 32'h0, 32'h0};
  int error_cnt = 0, cmp_count = 0, cycles = 0;
  dsf_status_outputs #(.TICK_CYCLES(10)) u_dsf_status_outputs (.clk_sys, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rtuRs485Sel,
    .rxDataStrobe, .aheadRunInput, .backwardRunInput, .supplyInRange, .constantSpeed,
    .heatsinkTemp, .outputCurrentPct, .linkLossFlagOut, .driveRunEnable(runEn), .motionState,
    .outputTerminalOne(t1), .outputTerminalTwo(t2), .relayOutput(rl));
  dsf_far_ctrl u_dsf_far_ctrl (.clk_sys, .termOne(t1), .termTwo(t2), .relayIn(rl), .seenLines);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1;
    // Only the bench timeout ends a hung access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic sel(input logic [5:0] c);
    apb(1'b1, 12'h00c, {10'h0, c, 2'h0, c, 2'h0, c});
  endtask
  task automatic outc(input logic [2:0] e);
    repeat (5) @(posedge clk_sys);
    chk({29'h0, seenLines}, {29'h0, e});
  endtask
  task automatic pulse;
    rxDataStrobe <= 1;
    @(posedge clk_sys);
    rxDataStrobe <= 0;
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard, run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    {psel, penable, pwrite, rtuRs485Sel, rxDataStrobe, constantSpeed} = '0;
    {aheadRunInput, backwardRunInput, supplyInRange, paddr, pwdata} = '0;
    heatsinkTemp = 8'h00;
    outputCurrentPct = 8'h64;
    reset = 1;
    repeat (2) @(posedge clk_sys);
    reset <= 0;
    for (int i = 0; i < 7; i++) begin
      rdc(12'(i * 4), rstVal[i]);
      chk({31'h0, er}, {31'h0, i == 6});
    end
    apb(1'b1, 12'h004, 32'h78);
    rdc(12'h004, 32'h6e);
    apb(1'b1, 12'h000, 32'h2710);
    rdc(12'h000, 32'h270f);
    apb(1'b1, 12'h008, 32'hfa);
    rdc(12'h008, 32'hc8);
    sel(6'd42);
    apb(1'b1, 12'h004, 32'h32);
    heatsinkTemp <= 8'h32;
    outc(3'h0);
    heatsinkTemp <= 8'h33;
    outc(3'h7);
    sel(6'd41);
    aheadRunInput <= 1;
    outc(3'h7);
    backwardRunInput <= 1;
    outc(3'h7);
    chk({30'h0, motionState}, 32'h0);
    chk({31'h0, runEn}, 32'h0);
    backwardRunInput <= 0;
    sel(6'd50);
    outc(3'h0);
    chk({30'h0, motionState}, 32'h0);
    chk({31'h0, runEn}, 32'h0);
    supplyInRange <= 1;
    outc(3'h7);
    chk({31'h0, runEn}, 32'h1);
    apb(1'b1, 12'h00c, {10'h0, 6'd50, 2'h0, 6'd52, 2'h0, 6'd51});
    outc(3'h5);
    {aheadRunInput, backwardRunInput} <= 2'b01;
    outc(3'h3);
    {aheadRunInput, backwardRunInput} <= 2'b00;
    outc(3'h1);
    apb(1'b1, 12'h008, 32'h64);
    sel(6'd43);
    aheadRunInput <= 1;
    outputCurrentPct <= 8'h32;
    outc(3'h0);
    constantSpeed <= 1;
    outc(3'h7);
    outputCurrentPct <= 8'h64;
    outc(3'h0);
    {outputCurrentPct, constantSpeed} <= {8'h32, 1'b0};
    apb(1'b1, 12'h010, 32'h0);
    outc(3'h7);
    sel(6'd32);
    apb(1'b1, 12'h000, 32'h2);
    rtuRs485Sel <= 1;
    pulse();
    outc(3'h0);
    repeat (20) @(posedge clk_sys);
    outc(3'h7);
    chk({26'h0, linkLossFlagOut}, 32'h1);
    pulse();
    outc(3'h0);
    repeat (25) @(posedge clk_sys);
    rtuRs485Sel <= 0;
    outc(3'h0);
    chk({26'h0, linkLossFlagOut}, 32'h0);
    give_verdict();
  end
endmodule // dsf_status_outputs_test
